// ==== common/string_cfg_pkg.sv ====
package string_cfg_pkg;
  // register offsets (byte addresses on the configuration port)
  localparam logic [7:0] LANG_LOW_OFFSET    = 8'h20;
  localparam logic [7:0] LANG_HIGH_OFFSET   = 8'h21;
  localparam logic [7:0] SERIAL_LEN_OFFSET  = 8'h22;
  localparam logic [7:0] MAKER_LEN_OFFSET   = 8'h23;
  // reset values
  localparam logic [7:0] LANG_LOW_RESET     = 8'h09;
  localparam logic [7:0] LANG_HIGH_RESET    = 8'h04;
  localparam logic [5:0] SERIAL_LEN_RESET   = 6'h18;
  localparam logic [6:0] MAKER_LEN_RESET    = 7'h00;
  // field widths and limits
  localparam int         SERIAL_LEN_W       = 6;
  localparam int         MAKER_LEN_W        = 7;
  localparam logic [5:0] SERIAL_LEN_MAX     = 6'h20;
  localparam logic [6:0] MAKER_LEN_MAX      = 7'h40;
  // string descriptor indices
  localparam logic [7:0] LANG_STR_INDEX     = 8'h00;
  localparam logic [7:0] SERIAL_STR_INDEX   = 8'h01;
  localparam logic [7:0] MAKER_STR_INDEX    = 8'h03;
  // descriptor type code for string descriptors
  localparam logic [7:0] STRING_DESC_TYPE   = 8'h03;
  // header bytes ahead of the string payload
  localparam logic [7:0] DESC_HEADER_LEN    = 8'h02;
  // number of language codes listed in index zero
  localparam logic [7:0] LANG_CODE_COUNT    = 8'h01;
endpackage

// ==== verilog/string_descriptor_config_regs.sv ====
module string_descriptor_config_regs
  import string_cfg_pkg::*;
(
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // custom enable flags from the configuration block
  input  wire logic       i_custom_text_enable,
  input  wire logic       i_custom_serial_enable,
  // register write/read port from EEPROM loader or SMBus slave
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_rvalid,
  // descriptor request from the hub's control endpoint
  input  wire logic       i_desc_req,
  input  wire logic [7:0] i_desc_index,
  output logic            o_desc_valid,
  output logic            o_desc_supported,
  output logic      [7:0] o_desc_length,
  output logic      [7:0] o_desc_type,
  output logic      [7:0] o_desc_payload_len,
  output logic      [15:0] o_lang_code,
  output logic      [7:0] o_lang_count,
  // live field values for the descriptor engine
  output logic      [5:0] o_serial_text_length,
  output logic      [6:0] o_maker_text_length
);

  logic [7:0] lang_code_low_byte_q, lang_code_low_byte_d;
  logic [7:0] lang_code_high_byte_q, lang_code_high_byte_d;
  logic [5:0] serial_text_length_q, serial_text_length_d;
  logic [6:0] maker_text_length_q, maker_text_length_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;
  logic       dvalid_q, dvalid_d;
  logic       dsup_q, dsup_d;
  logic [7:0] dlen_q, dlen_d;
  logic [7:0] dpay_q, dpay_d;

  // register writes, gated by the custom enables
  always_comb begin
    lang_code_low_byte_d  = lang_code_low_byte_q;
    lang_code_high_byte_d = lang_code_high_byte_q;
    serial_text_length_d  = serial_text_length_q;
    maker_text_length_d   = maker_text_length_q;
    if (i_reg_wr && i_custom_text_enable) begin
      if (i_reg_addr == LANG_LOW_OFFSET) begin
        lang_code_low_byte_d = i_reg_wdata;
      end
      if (i_reg_addr == LANG_HIGH_OFFSET) begin
        lang_code_high_byte_d = i_reg_wdata;
      end
      if (i_reg_addr == MAKER_LEN_OFFSET) begin
        // bit 7 dropped, length clamped
        if (i_reg_wdata[6:0] > MAKER_LEN_MAX) begin
          maker_text_length_d = MAKER_LEN_MAX;
        end else begin
          maker_text_length_d = i_reg_wdata[6:0];
        end
      end
    end
    if (i_reg_wr && i_custom_serial_enable &&
        i_reg_addr == SERIAL_LEN_OFFSET) begin
      if (i_reg_wdata[5:0] > SERIAL_LEN_MAX) begin
        serial_text_length_d = SERIAL_LEN_MAX;
      end else begin
        serial_text_length_d = i_reg_wdata[5:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lang_code_low_byte_q  <= LANG_LOW_RESET;
      lang_code_high_byte_q <= LANG_HIGH_RESET;
      serial_text_length_q  <= SERIAL_LEN_RESET;
      maker_text_length_q   <= MAKER_LEN_RESET;
    end else begin
      lang_code_low_byte_q  <= lang_code_low_byte_d;
      lang_code_high_byte_q <= lang_code_high_byte_d;
      serial_text_length_q  <= serial_text_length_d;
      maker_text_length_q   <= maker_text_length_d;
    end
  end

  // read path, one cycle latency, reserved bits zero
  always_comb begin
    rvalid_d = i_reg_rd;
    rdata_d  = 8'h00;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        LANG_LOW_OFFSET:   rdata_d = lang_code_low_byte_q;
        LANG_HIGH_OFFSET:  rdata_d = lang_code_high_byte_q;
        SERIAL_LEN_OFFSET: rdata_d = {2'h0, serial_text_length_q};
        MAKER_LEN_OFFSET:  rdata_d = {1'h0, maker_text_length_q};
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // descriptor answer, one cycle after the request
  always_comb begin
    dvalid_d = i_desc_req;
    dsup_d   = 1'b0;
    dpay_d   = 8'h00;
    if (i_desc_req) begin
      if (i_desc_index == LANG_STR_INDEX) begin
        dsup_d = 1'b1;
        dpay_d = {LANG_CODE_COUNT[6:0], 1'b0};
      end else if (i_desc_index == SERIAL_STR_INDEX) begin
        dsup_d = (serial_text_length_q != 6'h00);
        dpay_d = {2'h0, serial_text_length_q};
      end else if (i_desc_index == MAKER_STR_INDEX) begin
        dsup_d = (maker_text_length_q != 7'h00);
        dpay_d = {1'h0, maker_text_length_q};
      end
    end
    dlen_d = dsup_d ? 8'(dpay_d + DESC_HEADER_LEN) : 8'h00;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dvalid_q <= 1'b0;
      dsup_q   <= 1'b0;
      dlen_q   <= 8'h00;
      dpay_q   <= 8'h00;
    end else begin
      dvalid_q <= dvalid_d;
      dsup_q   <= dsup_d;
      dlen_q   <= dlen_d;
      dpay_q   <= dpay_d;
    end
  end

  // outputs straight from flip-flops, except descriptor type and language count, which are tied to constants
  assign o_reg_rdata          = rdata_q;
  assign o_reg_rvalid         = rvalid_q;
  assign o_desc_valid         = dvalid_q;
  assign o_desc_supported     = dsup_q;
  assign o_desc_length        = dlen_q;
  assign o_desc_type          = STRING_DESC_TYPE;
  assign o_desc_payload_len   = dpay_q;
  assign o_lang_code          = {lang_code_high_byte_q, lang_code_low_byte_q};
  assign o_lang_count         = LANG_CODE_COUNT;
  assign o_serial_text_length = serial_text_length_q;
  assign o_maker_text_length  = maker_text_length_q;

  // assertions, all on the one clock and quiet during reset
  default clocking dcb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // language high byte frozen while text writes are locked
  AST_LANG_HIGH_RO: assert property (
    !i_custom_text_enable
    |=> $stable(lang_code_high_byte_q))
    else $error("language high byte changed while locked");

  // language low byte frozen while text writes are locked
  AST_LANG_LOW_RO: assert property (
    !i_custom_text_enable
    |=> $stable(lang_code_low_byte_q))
    else $error("language low byte changed while locked");

  // serial length frozen while serial writes are locked
  AST_SERIAL_RO: assert property (
    !i_custom_serial_enable
    |=> $stable(serial_text_length_q))
    else $error("serial length changed while locked");

  // maker length frozen while text writes are locked
  AST_MAKER_RO: assert property (
    !i_custom_text_enable
    |=> $stable(maker_text_length_q))
    else $error("maker length changed while locked");

  // serial length never above its limit
  AST_SERIAL_MAX: assert property (
    serial_text_length_q
    <= SERIAL_LEN_MAX)
    else $error("serial length above limit");

  // maker length never above its limit
  AST_MAKER_MAX: assert property (
    maker_text_length_q
    <= MAKER_LEN_MAX)
    else $error("maker length above limit");

  // serial reserved bits read back as zero
  AST_RSVD_ZERO: assert property (
    i_reg_rd && i_reg_addr == SERIAL_LEN_OFFSET
    |=> o_reg_rvalid && o_reg_rdata[7:6] == 2'h0)
    else $error("serial reserved bits not zero");

  // maker reserved bit reads back as zero
  AST_MAKER_RSVD: assert property (
    i_reg_rd && i_reg_addr == MAKER_LEN_OFFSET
    |=> o_reg_rvalid && o_reg_rdata[7] == 1'b0)
    else $error("maker reserved bit not zero");

  // offsets outside this bank read as zero
  AST_UNMAPPED_ZERO: assert property (
    i_reg_rd && (i_reg_addr < LANG_LOW_OFFSET || i_reg_addr > MAKER_LEN_OFFSET)
    |=> o_reg_rdata == 8'h00)
    else $error("unmapped offset read not zero");

  // unlocked high byte write lands the next cycle
  AST_LANG_WRITE: assert property (
    i_reg_wr && i_custom_text_enable && i_reg_addr == LANG_HIGH_OFFSET
    |=> o_lang_code[15:8] == $past(i_reg_wdata))
    else $error("language high byte write lost");

  // unlocked maker length write within limit lands as written
  AST_MAKER_WRITE: assert property (
    i_reg_wr && i_custom_text_enable && i_reg_addr == MAKER_LEN_OFFSET &&
    i_reg_wdata[6:0] <= MAKER_LEN_MAX
    |=> o_maker_text_length == $past(i_reg_wdata[6:0]))
    else $error("maker length write lost");

  // maker length write above limit stops at the limit
  AST_MAKER_CLAMP: assert property (
    i_reg_wr && i_custom_text_enable && i_reg_addr == MAKER_LEN_OFFSET &&
    i_reg_wdata[6:0] > MAKER_LEN_MAX
    |=> o_maker_text_length == MAKER_LEN_MAX)
    else $error("maker length not clamped");

  // unlocked serial length write within limit lands as written
  AST_SERIAL_WRITE: assert property (
    i_reg_wr && i_custom_serial_enable && i_reg_addr == SERIAL_LEN_OFFSET &&
    i_reg_wdata[5:0] <= SERIAL_LEN_MAX
    |=> o_serial_text_length == $past(i_reg_wdata[5:0]))
    else $error("serial length write lost");

  // serial length write above limit stops at the limit
  AST_SERIAL_CLAMP: assert property (
    i_reg_wr && i_custom_serial_enable && i_reg_addr == SERIAL_LEN_OFFSET &&
    i_reg_wdata[5:0] > SERIAL_LEN_MAX
    |=> o_serial_text_length == SERIAL_LEN_MAX)
    else $error("serial length not clamped");

  // serial descriptor carries the stored length
  AST_SERIAL_DESC: assert property (
    i_desc_req && i_desc_index == SERIAL_STR_INDEX
    |=> o_desc_valid && o_desc_payload_len == {2'h0, $past(serial_text_length_q)})
    else $error("serial descriptor length wrong");

  // serial descriptor offered only for a non-zero length
  AST_SERIAL_PRES: assert property (
    i_desc_req && i_desc_index == SERIAL_STR_INDEX
    |=> o_desc_supported == ($past(serial_text_length_q) != 6'h00))
    else $error("serial descriptor presence wrong");

  // maker descriptor offered only for a non-zero length
  AST_MAKER_DESC: assert property (
    i_desc_req && i_desc_index == MAKER_STR_INDEX
    |=> o_desc_supported == ($past(maker_text_length_q) != 7'h00))
    else $error("maker descriptor presence wrong");

  // maker descriptor carries the stored length
  AST_MAKER_PAYLOAD: assert property (
    i_desc_req && i_desc_index == MAKER_STR_INDEX
    |=> o_desc_valid && o_desc_payload_len == {1'h0, $past(maker_text_length_q)})
    else $error("maker descriptor length wrong");

  // index zero lists exactly one two-byte language code
  AST_ONE_LANG: assert property (
    i_desc_req && i_desc_index == LANG_STR_INDEX
    |=> o_desc_supported && o_desc_payload_len == 8'h02)
    else $error("index zero not one language");

  // index zero total length is header plus one code
  AST_LANG_LEN: assert property (
    i_desc_req && i_desc_index == LANG_STR_INDEX
    |=> o_desc_length == 8'h04)
    else $error("index zero length wrong");

  // offered descriptors add the header to the payload
  AST_DESC_LENGTH: assert property (
    o_desc_valid && o_desc_supported
    |-> o_desc_length == 8'(o_desc_payload_len + DESC_HEADER_LEN))
    else $error("descriptor length not payload plus header");

  // refused descriptors report no length at all
  AST_DESC_REFUSED: assert property (
    o_desc_valid && !o_desc_supported
    |-> o_desc_length == 8'h00 && o_desc_payload_len == 8'h00)
    else $error("refused descriptor has a length");

endmodule

// ==== tb/cfg_host_model.sv ====
// eeprom loader / smbus host writing and reading config bytes
module cfg_host_model (
  // clock and read answer
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  // register port requests
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // one-cycle write strobe; bus shows inverse once released
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    // let the register update settle before the caller looks at it
    #1;
  endtask
  // one-cycle read strobe, answer taken the cycle after
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                        output logic v);
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule

// ==== tb/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import string_cfg_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ten = 1'b0, sen = 1'b0;
  logic wr, rd, rvalid, req = 1'b0, dv, dsup;
  logic [7:0] addr, wdata, rdata, idx = 8'h00, dlen, dtyp, dpay, lcnt;
  logic [15:0] lcode;
  logic [5:0] slen;
  logic [6:0] mlen;
  int n_fail = 0, cmp_count = 0;
  string_descriptor_config_regs i_dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_custom_text_enable(ten),
    .i_custom_serial_enable(sen), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_desc_req(req), .i_desc_index(idx),
    .o_desc_valid(dv), .o_desc_supported(dsup), .o_desc_length(dlen),
    .o_desc_type(dtyp), .o_desc_payload_len(dpay), .o_lang_code(lcode),
    .o_lang_count(lcnt), .o_serial_text_length(slen),
    .o_maker_text_length(mlen));
  cfg_host_model i_host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    i_host.rd_reg(a, d, v);
    chk({15'h0000, v}, 16'h0001);
    chk({8'h00, d}, {8'h00, exp});
  endtask
  // one descriptor request, answer judged the cycle after
  task automatic desc(input logic [7:0] i, input logic s,
                      input logic [7:0] p);
    @(posedge clk);
    req <= 1'b1;
    idx <= i;
    @(posedge clk);
    req <= 1'b0;
    #1;
    chk({15'h0000, dv}, 16'h0001);
    chk({15'h0000, dsup}, {15'h0000, s});
    chk({8'h00, dpay}, {8'h00, p});
    chk({8'h00, dlen}, s ? {8'h00, p + DESC_HEADER_LEN} : 16'h0000);
    chk({8'h00, dtyp}, 16'h0003);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog far beyond the fewer than a hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(8'h20, 8'h09);
    rd_chk(8'h21, 8'h04);
    rd_chk(8'h22, 8'h18);
    rd_chk(8'h23, 8'h00);
    rd_chk(8'h24, 8'h00);
    chk(lcode, 16'h0409);
    desc(8'h00, 1'b1, 8'h02);
    chk({8'h00, lcnt}, 16'h0001);
    desc(8'h01, 1'b1, 8'h18);
    desc(8'h03, 1'b0, 8'h00);
    $display("test reset done");
    i_host.wr_reg(8'h21, 8'hAA);
    i_host.wr_reg(8'h22, 8'h05);
    i_host.wr_reg(8'h23, 8'h10);
    rd_chk(8'h21, 8'h04);
    rd_chk(8'h22, 8'h18);
    rd_chk(8'h23, 8'h00);
    $display("test locked done");
    ten <= 1'b1;
    i_host.wr_reg(8'h23, 8'hFF);
    i_host.wr_reg(8'h22, 8'h05);
    i_host.wr_reg(8'h21, 8'hAA);
    rd_chk(8'h23, 8'h40);
    rd_chk(8'h22, 8'h18);
    chk(lcode, 16'hAA09);
    sen <= 1'b1;
    i_host.wr_reg(8'h22, 8'hFF);
    rd_chk(8'h22, 8'h20);
    i_host.wr_reg(8'h22, 8'h05);
    chk({10'h000, slen}, 16'h0005);
    desc(8'h01, 1'b1, 8'h05);
    desc(8'h03, 1'b1, 8'h40);
    desc(8'h02, 1'b0, 8'h00);
    $display("test unlocked done");
    i_host.wr_reg(8'h23, 8'h00);
    i_host.wr_reg(8'h22, 8'h00);
    chk({9'h000, mlen}, 16'h0000);
    desc(8'h03, 1'b0, 8'h00);
    desc(8'h01, 1'b0, 8'h00);
    $display("test zero length done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(8'h22, 8'h18);
    rd_chk(8'h23, 8'h00);
    chk(lcode, 16'h0409);
    $display("test second reset done");
    give_verdict();
  end
endmodule
